// ---- rtl/wss_regs.svh ----
// register offsets, field positions and reset values of the wake source
`ifndef WSS_REGS_SVH
`define WSS_REGS_SVH
`define WSS_ADDR_W 12
`define WSS_STATUS_OFS 12'h144
`define WSS_RESET_VAL 32'h0000_0000
`define WSS_FLAG_MASK 32'h0ff1_ff1f
`define WSS_LPI_MASK 32'h0000_6000
`define WSS_IDX_MASK 32'h0000_001f
`define WSS_PIN_LSB 20
`define WSS_PIN_MSB 27
`define WSS_V6_BIT 16
`define WSS_V4_BIT 15
`define WSS_LPI_TX_BIT 14
`define WSS_LPI_RX_BIT 13
`define WSS_ENGINE_BIT 12
`define WSS_PERFECT_BIT 11
`define WSS_MAGIC_BIT 10
`define WSS_BCAST_BIT 9
`define WSS_WUF_BIT 8
`define WSS_IDX_LSB 0
`define WSS_IDX_MSB 4
`define WSS_PIN_COUNT 8
`define WSS_NUM_FILTERS 32
`endif

// ---- rtl/wss_pkg.sv ----
// types shared by the wake source status block
package wss_pkg;
`include "wss_regs.svh"
  // register port request, all from core_clk logic
  typedef struct packed
  {
    logic [`WSS_ADDR_W-1:0] addr;
    logic [31:0] wrData;
    logic wrStb;
    logic rdStb;
  } wss_reg_req_t;
  // one-cycle qualified events from the mac and filter logic
  typedef struct packed
  {
    logic v6Syn;
    logic v4Syn;
    logic lpiTxExit;
    logic lpiRxExit;
    logic filterEngine;
    logic perfectAddr;
    logic magic;
    logic bcast;
    logic wakeupFrame;
    logic [`WSS_IDX_MSB:`WSS_IDX_LSB] filterIndex;
  } wss_frame_evt_t;
  // enables held in other control registers of the mac
  typedef struct packed
  {
    logic energyEfficientEnable;
    logic lpiTransmitWakeEnable;
    logic lpiReceiveWakeEnable;
  } wss_lpi_ctrl_t;
  typedef enum logic [1:0]
  {
    WSS_RUN,
    WSS_ENTERING,
    WSS_SUSPENDED,
    WSS_WAKING
  } wss_state_t;
endpackage

// ---- rtl/wss_pin_sync.sv ----
// three stage synchroniser with rising event detect for wake pins
`timescale 1ns/100ps
`include "wss_regs.svh"
module wss_pin_sync
#(
  parameter int WIDTH = `WSS_PIN_COUNT
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] riseEvt
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      logic [2:0] stage_reg;
      logic level_reg;
      logic rise_reg;
      wire agree = (stage_reg[1] == stage_reg[2]);
      wire change = agree && (stage_reg[2] != level_reg);
      // only the second and third stage are compared
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          stage_reg <= 3'h0;
          level_reg <= 1'b0;
          rise_reg <= 1'b0;
        end
        else if (clkEn)
        begin
          stage_reg <= {stage_reg[1:0], pinIn[i]};
          level_reg <= change ? stage_reg[2] : level_reg;
          rise_reg <= change && stage_reg[2];
        end
      end
      assign riseEvt[i] = rise_reg;
    end
  endgenerate
endmodule

// ---- rtl/wss_wake_source.sv ----
// wake source status register with its suspend and wake window
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`include "wss_regs.svh"
module wss_wake_source
#(
  parameter int PIN_COUNT = `WSS_PIN_COUNT,
  parameter int NUM_FILTERS = `WSS_NUM_FILTERS
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wss_pkg::wss_reg_req_t regReq,
  output logic [31:0] regRdData,
  input wire logic suspendStart,
  input wire logic suspendDone,
  input wire logic hostResume,
  input wire logic resumeDone,
  input wire logic [PIN_COUNT-1:0] pinWakeIn,
  input wss_pkg::wss_frame_evt_t frameEvt,
  input wss_pkg::wss_lpi_ctrl_t lpiCtrl,
  output logic wakeSignalReq,
  output logic suspendActive,
  output logic [31:0] wakeSourceStatus
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wss_pkg::wss_state_t state_reg;
  wss_pkg::wss_state_t state_next;
  logic [31:0] status_reg;
  logic [31:0] status_next;
  logic [31:0] rdData_reg;
  logic wakeReq_reg;
  logic [31:0] setVec;
  logic [PIN_COUNT-1:0] pinRise;

  // ----------------------------------------------------------------
  // wake pin synchronisers
  // ----------------------------------------------------------------
  // pins come from outside the clock domain; the synchroniser hands
  // back a single-cycle rise per pin once its level has settled
  wss_pin_sync
  #(
    .WIDTH(PIN_COUNT)
  )
  u_pin_sync
  (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .pinIn(pinWakeIn),
    .riseEvt(pinRise)
  );

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  // only one word is mapped; every other address reads as zero
  wire addrHit = (regReq.addr == `WSS_STATUS_OFS);
  wire wrHit = regReq.wrStb && addrHit;
  wire rdHit = regReq.rdStb && addrHit;
  // write one clears, reserved positions are masked away
  wire [31:0] clrVec = wrHit ? (regReq.wrData & `WSS_FLAG_MASK)
                             : 32'h0000_0000;
  wire idxClr = |(clrVec & `WSS_IDX_MASK);

  // ----------------------------------------------------------------
  // recording window
  // ----------------------------------------------------------------
  // events are only taken while fully suspended: never during entry
  // and never once the wake-up has started
  wire recordWin = (state_reg == wss_pkg::WSS_SUSPENDED);
  wire eeeOn = lpiCtrl.energyEfficientEnable;

  // qualify every source with the window and its own enables
  wire [PIN_COUNT-1:0] pinHit = pinRise & {PIN_COUNT{recordWin}};
  wire v6Hit = recordWin && frameEvt.v6Syn;
  wire v4Hit = recordWin && frameEvt.v4Syn;
  wire lpiTxHit = recordWin && frameEvt.lpiTxExit
                  && lpiCtrl.lpiTransmitWakeEnable && eeeOn;
  wire lpiRxHit = recordWin && frameEvt.lpiRxExit
                  && lpiCtrl.lpiReceiveWakeEnable && eeeOn;
  wire engineHit = recordWin && frameEvt.filterEngine;
  wire perfectHit = recordWin && frameEvt.perfectAddr;
  wire magicHit = recordWin && frameEvt.magic;
  wire bcastHit = recordWin && frameEvt.bcast;
  wire wufHit = recordWin && frameEvt.wakeupFrame;
  wire anyHit = (|pinHit) || v6Hit || v4Hit || lpiTxHit || lpiRxHit
                || engineHit || perfectHit || magicHit || bcastHit
                || wufHit;

  // ----------------------------------------------------------------
  // set vector
  // ----------------------------------------------------------------
  // every source seen in one cycle lands together, so a packet that
  // matches several conditions marks all of them
  always_comb
  begin
    setVec = 32'h0000_0000;
    setVec[`WSS_PIN_MSB:`WSS_PIN_LSB] = pinHit;
    setVec[`WSS_V6_BIT] = v6Hit;
    setVec[`WSS_V4_BIT] = v4Hit;
    setVec[`WSS_LPI_TX_BIT] = lpiTxHit;
    setVec[`WSS_LPI_RX_BIT] = lpiRxHit;
    setVec[`WSS_ENGINE_BIT] = engineHit;
    setVec[`WSS_PERFECT_BIT] = perfectHit;
    setVec[`WSS_MAGIC_BIT] = magicHit;
    setVec[`WSS_BCAST_BIT] = bcastHit;
    setVec[`WSS_WUF_BIT] = wufHit;
  end

  // ----------------------------------------------------------------
  // status next value
  // ----------------------------------------------------------------
  // flags: clear first, then set, so a set in the clearing cycle wins
  wire [31:0] flagKeep = status_reg & ~clrVec;
  wire [31:0] flagRaw = (flagKeep | setVec)
                        & `WSS_FLAG_MASK & ~`WSS_IDX_MASK;
  // the idle flags are held low while energy saving is off
  wire [31:0] flagVal = eeeOn ? flagRaw
                              : (flagRaw & ~`WSS_LPI_MASK);
  // the index follows the filter that matched; clearing any of its
  // bits empties the field unless a new match arrives the same cycle
  wire [`WSS_IDX_MSB:`WSS_IDX_LSB] idxOld =
    status_reg[`WSS_IDX_MSB:`WSS_IDX_LSB];
  wire [`WSS_IDX_MSB:`WSS_IDX_LSB] idxVal =
    wufHit ? frameEvt.filterIndex
           : (idxClr ? 5'h00 : idxOld);

  always_comb
  begin
    status_next = flagVal;
    status_next[`WSS_IDX_MSB:`WSS_IDX_LSB] = idxVal;
  end

  // ----------------------------------------------------------------
  // suspend and wake sequence
  // ----------------------------------------------------------------
  // the first recorded source starts the wake-up; a resume from the
  // host side also closes the window but records nothing
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      wss_pkg::WSS_RUN:
      begin
        if (suspendStart)
          state_next = wss_pkg::WSS_ENTERING;
      end
      wss_pkg::WSS_ENTERING:
      begin
        if (suspendDone)
          state_next = wss_pkg::WSS_SUSPENDED;
      end
      wss_pkg::WSS_SUSPENDED:
      begin
        if (anyHit || hostResume)
          state_next = wss_pkg::WSS_WAKING;
      end
      wss_pkg::WSS_WAKING:
      begin
        if (resumeDone)
          state_next = wss_pkg::WSS_RUN;
      end
      default:
      begin
        state_next = wss_pkg::WSS_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // everything freezes while the clock enable is low
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= wss_pkg::WSS_RUN;
      status_reg <= `WSS_RESET_VAL;
    end
    else if (clkEn)
    begin
      state_reg <= state_next;
      status_reg <= status_next;
    end
  end

  // wake request pulses once, when a recorded source ends suspend
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      wakeReq_reg <= 1'b0;
    else if (clkEn)
      wakeReq_reg <= recordWin && anyHit;
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // read data stands for exactly the cycle after the strobe; the
  // stored value already has reserved bits at zero
  wire [31:0] rdVal = rdHit ? status_reg : 32'h0000_0000;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdData_reg <= 32'h0000_0000;
    else if (clkEn)
      rdData_reg <= rdVal;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign regRdData = rdData_reg;
  assign wakeSignalReq = wakeReq_reg;
  assign suspendActive = (state_reg != wss_pkg::WSS_RUN);
  assign wakeSourceStatus = status_reg;
  // software must ignore the index while the frame flag is clear

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // nothing new appears while suspend is still being entered
  entry_ignored_a: assert property (
    clkEn && state_reg == wss_pkg::WSS_ENTERING
    |=> (status_reg & ~$past(status_reg) & ~`WSS_IDX_MASK) == 32'h0
  ) else $error("flag set while entering suspend");

  // nothing new appears once the wake-up has started
  waking_ignored_a: assert property (
    clkEn && state_reg == wss_pkg::WSS_WAKING
    |=> (status_reg & ~$past(status_reg) & ~`WSS_IDX_MASK) == 32'h0
  ) else $error("flag set after wake-up began");

  // every qualified source in one cycle lands together
  all_sources_a: assert property (
    clkEn && recordWin
    |=> (status_reg & $past(setVec)) == $past(setVec)
  ) else $error("matching source bit not recorded");

  // flags other than the idle pair only fall on a write; the index
  // is not a flag and may follow a new match
  flags_sticky_a: assert property (
    clkEn && !wrHit
    |=> ($past(status_reg) & ~status_reg & ~`WSS_LPI_MASK
         & ~`WSS_IDX_MASK) == 32'h0
  ) else $error("flag dropped without software clear");

  // a settled rise on pin 0 during suspend sets its bit next cycle
  pin_recorded_a: assert property (
    clkEn && recordWin && pinRise[0]
    |=> status_reg[`WSS_PIN_LSB]
  ) else $error("pin wake not recorded");

  // the transmit idle flag never rises with its enable off
  tx_lpi_gate_a: assert property (
    $rose(status_reg[`WSS_LPI_TX_BIT])
    |-> $past(lpiCtrl.lpiTransmitWakeEnable)
  ) else $error("transmit idle flag set while disabled");

  // the receive idle flag never rises with its enable off
  rx_lpi_gate_a: assert property (
    $rose(status_reg[`WSS_LPI_RX_BIT])
    |-> $past(lpiCtrl.lpiReceiveWakeEnable)
  ) else $error("receive idle flag set while disabled");

  // both idle flags are low the cycle after an enabled cycle with energy saving off
  lpi_forced_a: assert property (
    clkEn && !eeeOn
    |=> (status_reg & `WSS_LPI_MASK) == 32'h0
  ) else $error("idle flag high with energy saving off");

  // the matched filter number is captured with the frame flag
  index_capture_a: assert property (
    clkEn && wufHit
    |=> status_reg[`WSS_WUF_BIT]
        && status_reg[`WSS_IDX_MSB:`WSS_IDX_LSB]
           == $past(frameEvt.filterIndex)
  ) else $error("filter index not captured");

  // reserved positions always read back as zero
  reserved_zero_a: assert property (
    (status_reg & ~`WSS_FLAG_MASK) == 32'h0
  ) else $error("reserved status bit set");

  // a clear with no new event empties the bit
  clear_works_a: assert property (
    clkEn && wrHit && regReq.wrData[`WSS_MAGIC_BIT] && !magicHit
    |=> !status_reg[`WSS_MAGIC_BIT]
  ) else $error("write one did not clear flag");

  // a set in the clearing cycle survives
  set_wins_a: assert property (
    clkEn && magicHit
    |=> status_reg[`WSS_MAGIC_BIT]
  ) else $error("clear won over new event");

  // an ipv6 syn wake lands in its own bit
  v6_recorded_a: assert property (
    clkEn && recordWin && frameEvt.v6Syn |=> status_reg[`WSS_V6_BIT]
  ) else $error("v6 syn wake not recorded");

  // an ipv4 syn wake lands in its own bit
  v4_recorded_a: assert property (
    clkEn && recordWin && frameEvt.v4Syn |=> status_reg[`WSS_V4_BIT]
  ) else $error("v4 syn wake not recorded");

  // an enabled transmit idle exit sets its flag
  tx_lpi_set_a: assert property (
    clkEn && recordWin && eeeOn && frameEvt.lpiTxExit
    && lpiCtrl.lpiTransmitWakeEnable |=> status_reg[`WSS_LPI_TX_BIT]
  ) else $error("transmit idle wake not recorded");

  // an enabled receive idle exit sets its flag
  rx_lpi_set_a: assert property (
    clkEn && recordWin && eeeOn && frameEvt.lpiRxExit
    && lpiCtrl.lpiReceiveWakeEnable |=> status_reg[`WSS_LPI_RX_BIT]
  ) else $error("receive idle wake not recorded");

  // a filter engine frame lands in its own bit
  engine_recorded_a: assert property (
    clkEn && recordWin && frameEvt.filterEngine
    |=> status_reg[`WSS_ENGINE_BIT]
  ) else $error("filter engine wake not recorded");

  // an own address frame lands in its own bit
  perfect_recorded_a: assert property (
    clkEn && recordWin && frameEvt.perfectAddr
    |=> status_reg[`WSS_PERFECT_BIT]
  ) else $error("own address wake not recorded");

  // a broadcast frame lands in its own bit
  bcast_recorded_a: assert property (
    clkEn && recordWin && frameEvt.bcast |=> status_reg[`WSS_BCAST_BIT]
  ) else $error("broadcast wake not recorded");

  // a recorded source raises the wake request and closes the window
  wake_pulse_a: assert property (
    clkEn && anyHit
    |=> wakeSignalReq && state_reg == wss_pkg::WSS_WAKING
  ) else $error("recorded wake did not start waking");

  // the stored filter number stays inside the filter bank
  index_range_a: assert property (
    status_reg[`WSS_IDX_MSB:`WSS_IDX_LSB] < NUM_FILTERS
  ) else $error("filter index out of range");

  // read data of a mapped read appears in the cycle after it
  read_timing_a: assert property (
    clkEn && rdHit
    |=> regRdData == $past(status_reg)
  ) else $error("read data wrong or late");

endmodule

// ---- tb/wss_wake_source_tb.sv ----
// self-checking bench for the wake source status register
`timescale 1ns/100ps
`include "wss_regs.svh"
module wss_wake_source_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  wss_pkg::wss_reg_req_t regReq = '0;
  wss_pkg::wss_frame_evt_t frameEvt = '0;
  wss_pkg::wss_lpi_ctrl_t lpiCtrl = '0;
  logic suspendStart = 1'b0;
  logic suspendDone = 1'b0;
  logic hostResume = 1'b0;
  logic resumeDone = 1'b0;
  logic [7:0] pins = 8'h00;
  logic [31:0] regRdData;
  logic [31:0] statusImg;
  logic wakeSignalReq;
  logic suspendActive;
  logic [31:0] expQ[$];
  logic [1:0] wakeQ[$];
  logic inSus = 1'b0;
  logic [1:0] note;
  logic [31:0] expRd;
  logic rdLate = 1'b0;
  logic evLate = 1'b0;
  int errorCnt = 0;
  int checksDone = 0;
  integer seed = 32'h7b68e36e;
  int p;
  logic [4:0] idx;
  logic [31:0] bitv;

  wss_wake_source wss_wake_source_i
  (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .regReq(regReq),
    .regRdData(regRdData),
    .suspendStart(suspendStart),
    .suspendDone(suspendDone),
    .hostResume(hostResume),
    .resumeDone(resumeDone),
    .pinWakeIn(pins),
    .frameEvt(frameEvt),
    .lpiCtrl(lpiCtrl),
    .wakeSignalReq(wakeSignalReq),
    .suspendActive(suspendActive),
    .wakeSourceStatus(statusImg)
  );

  // 20 mhz core clock
  always #25 core_clk = ~core_clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task endOfTest;
    if (errorCnt == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // read notes the expected word; the monitor compares it a cycle later
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regReq.addr <= a;
    regReq.rdStb <= 1'b1;
    expQ.push_back(e);
    @(posedge core_clk);
    regReq.rdStb <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regReq.addr <= a;
    regReq.wrData <= d;
    regReq.wrStb <= 1'b1;
    @(posedge core_clk);
    regReq.wrStb <= 1'b0;
  endtask

  // one-cycle event pulse; w says whether a wake request must follow
  task ev(input logic [13:0] e, input logic w);
    @(posedge core_clk);
    frameEvt <= wss_pkg::wss_frame_evt_t'(e);
    wakeQ.push_back({inSus, w});
    @(posedge core_clk);
    frameEvt <= '0;
  endtask

  task sus;
    @(posedge core_clk);
    suspendStart <= 1'b1;
    @(posedge core_clk);
    suspendStart <= 1'b0;
    suspendDone <= 1'b1;
    @(posedge core_clk);
    suspendDone <= 1'b0;
    inSus = 1'b1;
  endtask

  // host resume is ignored if a recorded event already started waking
  task res;
    @(posedge core_clk);
    hostResume <= 1'b1;
    @(posedge core_clk);
    hostResume <= 1'b0;
    resumeDone <= 1'b1;
    @(posedge core_clk);
    resumeDone <= 1'b0;
    inSus = 1'b0;
  endtask

  // ----------------------------------------
  // monitor: takes the oldest note when a result stands
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    rdLate <= regReq.rdStb;
    evLate <= |frameEvt;
  end

  always @(negedge core_clk)
  begin
    if (rdLate)
    begin
      expRd = expQ.pop_front();
      chk(regRdData, expRd);
      chk(statusImg, expRd);
    end
    if (evLate)
    begin
      note = wakeQ.pop_front();
      chk({31'h0, wakeSignalReq}, {31'h0, note[0]});
      chk({31'h0, suspendActive}, {31'h0, note[1]});
    end
  end

  // watchdog, far beyond the roughly 400 cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errorCnt++;
    endOfTest;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(`WSS_STATUS_OFS, 32'h0);
    rd(12'h148, 32'h0);
    ev(14'h0080, 1'b0);
    // event while entering suspend must be dropped
    @(posedge core_clk);
    suspendStart <= 1'b1;
    @(posedge core_clk);
    suspendStart <= 1'b0;
    frameEvt <= wss_pkg::wss_frame_evt_t'(14'h0080);
    wakeQ.push_back(2'b10);
    inSus = 1'b1;
    @(posedge core_clk);
    frameEvt <= '0;
    suspendDone <= 1'b1;
    @(posedge core_clk);
    suspendDone <= 1'b0;
    rd(`WSS_STATUS_OFS, 32'h0);
    // one packet, several matches, top filter index; then waking ignores
    ev(14'h21bf, 1'b1);
    ev(14'h1063, 1'b0);
    res;
    rd(`WSS_STATUS_OFS, 32'h0001_0d1f);
    wr(`WSS_STATUS_OFS, 32'hffff_ffff);
    rd(`WSS_STATUS_OFS, 32'h0);
    // each frame source alone: set, survive zero writes, clear by one
    for (int i = 5; i < 14; i++)
    begin
      if (i == 10 || i == 11)
        continue;
      bitv = 32'h1 << (i + 3);
      sus;
      ev(14'h1 << i, 1'b1);
      res;
      wr(`WSS_STATUS_OFS, ~bitv);
      rd(`WSS_STATUS_OFS, bitv);
      wr(`WSS_STATUS_OFS, bitv);
      rd(`WSS_STATUS_OFS, 32'h0);
    end
    // every enable combination for both idle exits
    for (int c = 0; c < 8; c++)
    begin
      lpiCtrl <= wss_pkg::wss_lpi_ctrl_t'(c[2:0]);
      sus;
      ev(14'h0800, c[2] & c[1]);
      res;
      rd(`WSS_STATUS_OFS, {17'h0, c[2] & c[1], 14'h0});
      sus;
      ev(14'h0400, c[2] & c[0]);
      res;
      // the transmit flag of this pass is still set where c[2] and c[1] enabled it
      bitv = {17'h0, c[2] & c[1], c[2] & c[0], 13'h0};
      rd(`WSS_STATUS_OFS, bitv);
      wr(`WSS_STATUS_OFS, 32'h6000);
    end
    // dropping the energy saving enable forces both idle flags low
    lpiCtrl <= 3'h7;
    sus;
    ev(14'h0c00, 1'b1);
    res;
    rd(`WSS_STATUS_OFS, 32'h6000);
    lpiCtrl <= 3'h3;
    rd(`WSS_STATUS_OFS, 32'h0);
    lpiCtrl <= 3'h7;
    // random wake pin; the synchroniser needs a few cycles
    p = $random(seed) & 7;
    sus;
    @(posedge core_clk);
    pins <= 8'h1 << p;
    repeat (8) @(posedge core_clk);
    res;
    rd(`WSS_STATUS_OFS, 32'h1 << (20 + p));
    pins <= 8'h00;
    wr(`WSS_STATUS_OFS, 32'h0ff0_0000);
    rd(`WSS_STATUS_OFS, 32'h0);
    // clear and new set in the same cycle: set wins
    sus;
    @(posedge core_clk);
    frameEvt <= wss_pkg::wss_frame_evt_t'(14'h0080);
    wakeQ.push_back({inSus, 1'b1});
    regReq.addr <= `WSS_STATUS_OFS;
    regReq.wrData <= 32'h400;
    regReq.wrStb <= 1'b1;
    @(posedge core_clk);
    frameEvt <= '0;
    regReq.wrStb <= 1'b0;
    res;
    rd(`WSS_STATUS_OFS, 32'h400);
    // a frozen clock enable must swallow the clearing write
    @(posedge core_clk);
    clkEn <= 1'b0;
    wr(`WSS_STATUS_OFS, 32'h400);
    @(posedge core_clk);
    clkEn <= 1'b1;
    rd(`WSS_STATUS_OFS, 32'h400);
    wr(`WSS_STATUS_OFS, 32'h400);
    // random filter index; clearing an index bit leaves the frame flag
    idx = 5'($random(seed));
    sus;
    ev({9'h001, idx}, 1'b1);
    res;
    rd(`WSS_STATUS_OFS, {23'h0, 1'b1, 3'h0, idx});
    wr(`WSS_STATUS_OFS, 32'h1);
    rd(`WSS_STATUS_OFS, 32'h100);
    wr(`WSS_STATUS_OFS, 32'h100);
    rd(`WSS_STATUS_OFS, 32'h0);
    repeat (2) @(posedge core_clk);
    endOfTest;
  end
endmodule
